// *** hw/loader_consts.vh ***
// Constants for the serial clock program loader
`ifndef LOADER_CONSTS_VH
`define LOADER_CONSTS_VH
`define UNLOCK_MIN_ONES 3'h5
`define FRAME_BITS 5'h18
`define DATA_BITS 5'h15
`define WD_TIME_US 2000
`define CLK_MHZ 200
`define ADDR_PIX_A 3'h0
`define ADDR_PIX_B 3'h1
`define ADDR_PIX_C 3'h2
`define ADDR_MEM 3'h3
`define ADDR_RSVD 3'h4
`define ADDR_DIV 3'h5
`define ADDR_CTRL 3'h6
`define IDX_MSB 20
`define IDX_LSB 17
`define FB_MSB 16
`define FB_LSB 10
`define PD_MSB 9
`define PD_LSB 7
`define RC_MSB 6
`define RC_LSB 0
`define FB_OFFSET 8'h03
`define RC_OFFSET 8'h02
`define IDX_OFF 4'hE
`define IDX_MUX_MEM 4'hF
`define DIV_W 3
`define CTRL_W 8
`endif

// *** hw/edge_sync.v ***
// Two-stage synchroniser with edge detection for one link pin
module edge_sync (
   input wire clk_sys_i,
   input wire rst_b_i,
   input wire pin_i,
   output wire level_o,
   output wire rise_o,
   output wire fall_o
);
   reg meta_q;
   reg sync_q;
   reg last_q;

   // First stage feeds only the second
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // Edges from the stable stages
   assign level_o = sync_q;
   assign rise_o = sync_q & ~last_q;
   assign fall_o = ~sync_q & last_q;
endmodule // edge_sync

// *** hw/word_file.v ***
// Small register file for the received programming words
`include "loader_consts.vh"
module word_file #(
   parameter WIDTH = 21
) (
   input wire clk_sys_i,
   input wire rst_b_i,
   input wire wr_i,
   input wire [2:0] addr_i,
   input wire [WIDTH-1:0] data_i,
   input wire [2:0] rd_addr_i,
   output reg [WIDTH-1:0] rd_data_o
);
   reg [WIDTH-1:0] mem_q [0:7];
   integer i;

   // Writes; reserved slot never stored
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (i = 0; i < 8; i = i + 1) begin
            mem_q[i] <= {WIDTH{1'b0}};
         end
         rd_data_o <= {WIDTH{1'b0}};
      end else begin
         if (wr_i && addr_i != `ADDR_RSVD) begin
            mem_q[addr_i] <= data_i;
         end
         rd_data_o <= mem_q[rd_addr_i];
      end
   end
endmodule // word_file

// *** hw/serial_clock_program_loader.v ***
// Serial program receiver, register file and oscillator word decode
`include "loader_consts.vh"
module serial_clock_program_loader #(
   parameter WD_CYCLES = `WD_TIME_US * `CLK_MHZ,
   parameter WORD_W = 21
) (
   input wire clk_sys_i,
   input wire rst_b_i,
   input wire select_line_zero_i,
   input wire select_line_one_i,
   output reg program_error_out_b_o,
   output reg [1:0] pixel_select_o,
   output reg pixel_on_ref_o,
   output reg memory_on_ref_o,
   output reg [3:0] pixel_index_o,
   output reg [7:0] pixel_feedback_count_o,
   output reg [7:0] pixel_post_divide_o,
   output reg [7:0] pixel_reference_count_o,
   output reg pixel_osc_off_o,
   output reg pixel_from_memory_o,
   output reg [3:0] memory_index_o,
   output reg [7:0] memory_feedback_count_o,
   output reg [7:0] memory_post_divide_o,
   output reg [7:0] memory_reference_count_o,
   output reg memory_index_bad_o,
   output reg [`DIV_W-1:0] load_divide_register_o,
   output reg [`CTRL_W-1:0] control_register_o,
   output reg load_pulse_o
);
   // Receiver states
   localparam ST_LOCKED = 4'b0001;
   localparam ST_START = 4'b0010;
   localparam ST_BITS = 4'b0100;
   localparam ST_STOP = 4'b1000;

   // Feedback count from its code
   function [7:0] fb_count;
      input [6:0] code;
      begin
         fb_count = {1'b0, code} + `FB_OFFSET;
      end
   endfunction

   // Reference count from its code
   function [7:0] rc_count;
      input [6:0] code;
      begin
         rc_count = {1'b0, code} + `RC_OFFSET;
      end
   endfunction

   // Post divider value from its code
   function [7:0] post_div;
      input [2:0] code;
      begin
         post_div = 8'h01 << code;
      end
   endfunction

   wire clk_lvl;
   wire clk_rise;
   wire clk_fall;
   wire dat_lvl;
   wire dat_rise;
   wire dat_fall;
   wire [WORD_W-1:0] rd_data;

   // Link pins into the internal domain
   edge_sync u_clk_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .pin_i(select_line_zero_i),
      .level_o(clk_lvl),
      .rise_o(clk_rise),
      .fall_o(clk_fall)
   );
   edge_sync u_dat_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .pin_i(select_line_one_i),
      .level_o(dat_lvl),
      .rise_o(dat_rise),
      .fall_o(dat_fall)
   );

   reg [3:0] state_q;
   reg [2:0] ones_q;
   reg [4:0] count_q;
   reg [23:0] shift_q;
   reg fall_dat_q;
   reg [31:0] wd_q;
   reg wd_expired_q;
   reg [31:0] settle_q;
   reg wr_q;
   reg [2:0] wr_addr_q;
   reg [WORD_W-1:0] wr_data_q;
   reg [2:0] rd_addr_q;
   reg [1:0] raw_sel_q;

   wire any_edge = clk_rise | clk_fall | dat_rise | dat_fall;
   wire wd_hit = (wd_q == WD_CYCLES - 1);

   // Watchdog restarted by any pin transition
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wd_q <= 32'h00000000;
         wd_expired_q <= 1'b0;
      end else if (any_edge) begin
         wd_q <= 32'h00000000;
         wd_expired_q <= 1'b0;
      end else if (!wd_expired_q) begin
         if (wd_hit) begin
            wd_expired_q <= 1'b1;
         end else begin
            wd_q <= wd_q + 32'h00000001;
         end
      end
   end

   // Select pins pass only after the watchdog expires
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         raw_sel_q <= 2'h0;
         pixel_select_o <= 2'h0;
      end else begin
         raw_sel_q <= {dat_lvl, clk_lvl};
         if (wd_expired_q) begin
            pixel_select_o <= raw_sel_q;
         end
      end
   end

   // Unlock, framing, decoding and load strobe
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_LOCKED;
         ones_q <= 3'h0;
         count_q <= 5'h00;
         shift_q <= 24'h000000;
         fall_dat_q <= 1'b0;
         wr_q <= 1'b0;
         wr_addr_q <= 3'h0;
         wr_data_q <= {WORD_W{1'b0}};
         program_error_out_b_o <= 1'b1;
      end else begin
         wr_q <= 1'b0;
         if (clk_fall) begin
            fall_dat_q <= dat_lvl; // Complement phase
         end
         // A pin edge in the expiry cycle wins, so no first rise is lost
         if (wd_expired_q && !any_edge) begin
            state_q <= ST_LOCKED; // Relock, drop word
            ones_q <= 3'h0;
            count_q <= 5'h00;
         end else if (clk_rise) begin
            case (state_q)
               ST_LOCKED: begin
                  // Plain-level unlock pattern
                  if (dat_lvl) begin
                     if (ones_q != `UNLOCK_MIN_ONES) begin
                        ones_q <= ones_q + 3'h1;
                     end
                  end else begin
                     if (ones_q == `UNLOCK_MIN_ONES) begin
                        state_q <= ST_START;
                        program_error_out_b_o <= 1'b1;
                     end
                     ones_q <= 3'h0;
                  end
               end
               ST_START: begin
                  // Plain start bit, taken as a high level
                  if (dat_lvl) begin
                     state_q <= ST_BITS;
                     count_q <= 5'h00;
                  end else begin
                     state_q <= ST_LOCKED;
                     program_error_out_b_o <= 1'b0;
                  end
               end
               ST_BITS: begin
                  if (fall_dat_q == dat_lvl) begin
                     // Encoding failure or stop after short count
                     state_q <= ST_LOCKED;
                     count_q <= 5'h00;
                     program_error_out_b_o <= 1'b0;
                  end else begin
                     // LSB first, so shift in at the top
                     shift_q <= {dat_lvl, shift_q[23:1]};
                     count_q <= count_q + 5'h01;
                     if (count_q == `FRAME_BITS - 5'h01) begin
                        state_q <= ST_STOP;
                     end
                  end
               end
               ST_STOP: begin
                  // Stop is plain high at both edges
                  if (dat_lvl && fall_dat_q) begin
                     wr_q <= 1'b1; // Load strobe
                     wr_addr_q <= shift_q[23:21];
                     wr_data_q <= shift_q[20:0];
                  end else begin
                     // Extra encoded bit or bad stop
                     program_error_out_b_o <= 1'b0;
                  end
                  state_q <= ST_LOCKED; // Relock after load
                  count_q <= 5'h00;
               end
               default: begin
                  state_q <= ST_LOCKED;
               end
            endcase
         end
      end
   end

   // Register file; reserved slot dropped inside
   word_file #(.WIDTH(WORD_W)) u_words (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .wr_i(wr_q),
      .addr_i(wr_addr_q),
      .data_i(wr_data_q),
      .rd_addr_i(rd_addr_q),
      .rd_data_o(rd_data)
   );

   // Active pixel word follows the gated selects
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_addr_q <= `ADDR_PIX_A;
      end else if (pixel_select_o[1]) begin
         rd_addr_q <= `ADDR_PIX_C;
      end else if (pixel_select_o[0]) begin
         rd_addr_q <= `ADDR_PIX_B;
      end else begin
         rd_addr_q <= `ADDR_PIX_A;
      end
   end

   // Field decode of the active pixel word
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pixel_index_o <= 4'h0;
         pixel_feedback_count_o <= 8'h00;
         pixel_post_divide_o <= 8'h00;
         pixel_reference_count_o <= 8'h00;
         pixel_osc_off_o <= 1'b0;
         pixel_from_memory_o <= 1'b0;
      end else begin
         pixel_index_o <= rd_data[`IDX_MSB:`IDX_LSB];
         pixel_feedback_count_o <= fb_count(rd_data[`FB_MSB:`FB_LSB]);
         pixel_post_divide_o <= post_div(rd_data[`PD_MSB:`PD_LSB]);
         pixel_reference_count_o <= rc_count(rd_data[`RC_MSB:`RC_LSB]);
         pixel_osc_off_o <= (rd_data[`IDX_MSB:`IDX_LSB] == `IDX_OFF) ||
            (rd_data[`IDX_MSB:`IDX_LSB] == `IDX_MUX_MEM);
         pixel_from_memory_o <=
            (rd_data[`IDX_MSB:`IDX_LSB] == `IDX_MUX_MEM);
      end
   end

   // Memory, divide and control words captured at load
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         memory_index_o <= 4'h0;
         memory_feedback_count_o <= 8'h00;
         memory_post_divide_o <= 8'h00;
         memory_reference_count_o <= 8'h00;
         memory_index_bad_o <= 1'b0;
         load_divide_register_o <= {`DIV_W{1'b0}};
         control_register_o <= {`CTRL_W{1'b0}};
         load_pulse_o <= 1'b0;
      end else begin
         load_pulse_o <= wr_q && (wr_addr_q != `ADDR_RSVD);
         if (wr_q && wr_addr_q == `ADDR_MEM) begin
            memory_index_o <= wr_data_q[`IDX_MSB:`IDX_LSB];
            memory_feedback_count_o <=
               fb_count(wr_data_q[`FB_MSB:`FB_LSB]);
            memory_post_divide_o <= post_div(wr_data_q[`PD_MSB:`PD_LSB]);
            memory_reference_count_o <=
               rc_count(wr_data_q[`RC_MSB:`RC_LSB]);
            // Code 0000 reserved; memory clock stays running
            memory_index_bad_o <= (wr_data_q[`IDX_MSB:`IDX_LSB] == 4'h0);
         end
         if (wr_q && wr_addr_q == `ADDR_DIV) begin
            load_divide_register_o <=
               wr_data_q[WORD_W-1:WORD_W-`DIV_W];
         end
         if (wr_q && wr_addr_q == `ADDR_CTRL) begin
            control_register_o <=
               wr_data_q[WORD_W-1:WORD_W-`CTRL_W];
         end
      end
   end

   // Reference hold for one timeout after a load of the active pixel word or the memory word
   wire hit_pix = wr_q && (wr_addr_q == rd_addr_q);
   wire hit_mem = wr_q && (wr_addr_q == `ADDR_MEM);
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         settle_q <= 32'h00000000;
         pixel_on_ref_o <= 1'b0;
         memory_on_ref_o <= 1'b0;
      end else if (hit_pix || hit_mem) begin
         settle_q <= WD_CYCLES;
         pixel_on_ref_o <= hit_pix | pixel_on_ref_o;
         memory_on_ref_o <= hit_mem | memory_on_ref_o;
      end else if (settle_q != 32'h00000000) begin
         settle_q <= settle_q - 32'h00000001;
      end else begin
         pixel_on_ref_o <= 1'b0;
         memory_on_ref_o <= 1'b0;
      end
   end
endmodule // serial_clock_program_loader

// *** sim/loader_checker.sv ***
// Concurrent checks on the program loader ports
module loader_checker #(
   parameter WD_CYCLES = 400000
) (
   input logic clk_sys_i,
   input logic rst_b_i,
   input logic select_line_zero_i,
   input logic select_line_one_i,
   input logic program_error_out_b_o,
   input logic [1:0] pixel_select_o,
   input logic memory_on_ref_o,
   input logic [3:0] pixel_index_o,
   input logic [7:0] pixel_feedback_count_o,
   input logic [7:0] pixel_post_divide_o,
   input logic pixel_osc_off_o,
   input logic pixel_from_memory_o,
   input logic [3:0] memory_index_o,
   input logic memory_index_bad_o,
   input logic load_pulse_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] pins_q;
   int idle_q;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   // Cycles since either pin last moved
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pins_q <= 2'h0;
         idle_q <= 0;
      end else begin
         pins_q <= {select_line_one_i, select_line_zero_i};
         if (pins_q != {select_line_one_i, select_line_zero_i})
            idle_q <= 0;
         else if (idle_q < WD_CYCLES + 100)
            idle_q <= idle_q + 1;
      end
   end

   a_pulse_single: assert property (load_pulse_o |=> !load_pulse_o)
      else $error("load pulse longer than one cycle");
   a_pulse_on_stop: assert property (load_pulse_o |->
      select_line_zero_i && select_line_one_i)
      else $error("load pulse without a stop bit");
   a_load_no_error: assert property (load_pulse_o |->
      program_error_out_b_o)
      else $error("load while error flagged");
   a_error_release: assert property ($rose(program_error_out_b_o) |->
      select_line_zero_i && !select_line_one_i)
      else $error("error released outside unlock");
   a_error_held: assert property (!program_error_out_b_o &&
      select_line_one_i |=> !program_error_out_b_o)
      else $error("error released early");
   a_select_gated: assert property ($changed(pixel_select_o) |->
      idle_q >= WD_CYCLES - 4)
      else $error("select changed before watchdog expiry");
   a_select_follows: assert property (idle_q == WD_CYCLES + 20 |->
      pixel_select_o == {select_line_one_i, select_line_zero_i})
      else $error("select not taken after watchdog expiry");
   a_fb_range: assert property (pixel_feedback_count_o != 8'h00 |->
      pixel_feedback_count_o >= 8'h03 && pixel_feedback_count_o <= 8'h82)
      else $error("feedback count out of range");
   a_post_onehot: assert property (pixel_post_divide_o != 8'h00 |->
      $onehot(pixel_post_divide_o))
      else $error("post divider not a power of two");
   a_osc_flags: assert property (
      pixel_osc_off_o == (pixel_index_o[3:1] == 3'h7) &&
      pixel_from_memory_o == (pixel_index_o == 4'hF))
      else $error("oscillator flags disagree with index");
   a_mem_bad_flag: assert property (memory_index_bad_o |->
      memory_index_o == 4'h0)
      else $error("bad memory index flag wrong");
   a_mem_settle: assert property ($rose(memory_on_ref_o) |=>
      memory_on_ref_o [*8])
      else $error("memory settle too short");

   c_load: cover property (load_pulse_o);
   c_error: cover property ($fell(program_error_out_b_o));
   c_mux: cover property (pixel_from_memory_o);
   c_settle: cover property ($rose(memory_on_ref_o));
endmodule // loader_checker

bind serial_clock_program_loader loader_checker #(.WD_CYCLES(WD_CYCLES)) CHK (
   .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
   .select_line_zero_i(select_line_zero_i),
   .select_line_one_i(select_line_one_i),
   .program_error_out_b_o(program_error_out_b_o),
   .pixel_select_o(pixel_select_o), .memory_on_ref_o(memory_on_ref_o),
   .pixel_index_o(pixel_index_o),
   .pixel_feedback_count_o(pixel_feedback_count_o),
   .pixel_post_divide_o(pixel_post_divide_o),
   .pixel_osc_off_o(pixel_osc_off_o),
   .pixel_from_memory_o(pixel_from_memory_o),
   .memory_index_o(memory_index_o), .memory_index_bad_o(memory_index_bad_o),
   .load_pulse_o(load_pulse_o));

// *** sim/link_driver.sv ***
// Graphics controller model driving the select pins as a serial link
module link_driver (
   input logic clk_i,
   output logic ser_clk_o,
   output logic ser_data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins idle low at start
   initial begin
      ser_clk_o = 1'b0;
      ser_data_o = 1'b0;
   end

   // Set both pins after a falling edge, hold six cycles
   task automatic step(input logic c, input logic d);
      @(negedge clk_i);
      ser_clk_o <= c;
      ser_data_o <= d;
      repeat (5) @(negedge clk_i);
   endtask

   // Unencoded level: fall then rise with same data
   task automatic plain(input logic d);
      step(1'b0, d);
      step(1'b1, d);
   endtask

   // Fault codes: bit index bad encoding, 97 no stop, 98 start, 99 stop
   task automatic frame(input logic [20:0] d, input logic [2:0] a,
                        input int ones, input int nb, input int bad);
      logic [24:0] w;
      logic b;
      w = {1'b0, a, d};
      repeat (ones) plain(1'b1);
      plain(1'b0);
      plain(bad != 98);
      for (int i = 0; i < nb; i++) begin
         b = w[i];
         step(1'b1, ~b ^ (i == bad));
         step(1'b0, ~b ^ (i == bad));
         step(1'b0, b);
         step(1'b1, b);
      end
      if (bad != 97) begin
         plain(bad != 99);
         step(ser_clk_o, ser_data_o);
      end
   endtask
endmodule // link_driver

// *** sim/serial_clock_program_loader_bench.sv ***
// Self-checking bench for the serial clock program loader
module serial_clock_program_loader_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WD = 200;
   logic clk_sys_i, rst_b_i, select_line_zero_i, select_line_one_i;
   logic program_error_out_b_o, pixel_on_ref_o, memory_on_ref_o;
   logic pixel_osc_off_o, pixel_from_memory_o, memory_index_bad_o;
   logic load_pulse_o;
   logic [1:0] pixel_select_o;
   logic [3:0] pixel_index_o, memory_index_o;
   logic [7:0] pixel_feedback_count_o, pixel_post_divide_o;
   logic [7:0] pixel_reference_count_o, memory_feedback_count_o;
   logic [7:0] memory_post_divide_o, memory_reference_count_o;
   logic [2:0] load_divide_register_o;
   logic [7:0] control_register_o;
   int fails = 0;
   int n_checks = 0;
   int pulses = 0;
   int nb_t[5] = '{24, 23, 25, 24, 24};
   int bad_t[5] = '{7, -1, -1, 98, 99};

   serial_clock_program_loader #(.WD_CYCLES(WD)) DUT (.*);
   link_driver DRV (.clk_i(clk_sys_i), .ser_clk_o(select_line_zero_i),
                    .ser_data_o(select_line_one_i));

   // 200 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   // Count load strobes
   always @(posedge clk_sys_i) begin
      if (load_pulse_o === 1'b1) pulses <= pulses + 1;
   end

   task automatic cmp(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic pause(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   // Bound on the whole run
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      fails++;
      conclude();
   end

   // Main sequence
   initial begin
      rst_b_i = 1'b0;
      pause(3);
      rst_b_i = 1'b1;
      pause(5);
      cmp("error", 1, program_error_out_b_o);
      cmp("fb rst", 8'h03, pixel_feedback_count_o);
      cmp("post rst", 8'h01, pixel_post_divide_o);
      cmp("ref rst", 8'h02, pixel_reference_count_o);
      $display("end reset test");
      // Memory word for 79 MHz, band index 6
      DRV.frame(21'h0D349B, 3'h3, 5, 24, -1);
      pause(20);
      cmp("pulses", 1, pulses);
      cmp("mem index", 4'h6, memory_index_o);
      cmp("mem fb", 8'h50, memory_feedback_count_o);
      cmp("mem post", 8'h02, memory_post_divide_o);
      cmp("mem ref", 8'h1D, memory_reference_count_o);
      cmp("mem settle", 1, memory_on_ref_o);
      cmp("sel held", 2'h0, pixel_select_o);
      $display("end memory word test");
      // Active pixel word with oscillator off, then muxed
      for (int k = 0; k < 2; k++) begin
         DRV.frame({4'hE + k[3:0], 7'h0A, 3'h7, 7'h05}, 3'h0, 5, 24, -1);
         pause(20);
         cmp("pix index", 4'hE + k[3:0], pixel_index_o);
         cmp("osc off", 1, pixel_osc_off_o);
         cmp("from mem", k, pixel_from_memory_o);
         cmp("pix fb", 8'h0D, pixel_feedback_count_o);
         cmp("pix post", 8'h80, pixel_post_divide_o);
         cmp("pix ref", 8'h07, pixel_reference_count_o);
         cmp("pix settle", 1, pixel_on_ref_o);
      end
      $display("end pixel word test");
      // Narrow registers, reserved slot, short unlock
      DRV.frame(21'h140000, 3'h5, 5, 24, -1);
      DRV.frame(21'h14A000, 3'h6, 5, 24, -1);
      DRV.frame(21'h1FFFFF, 3'h4, 5, 24, -1);
      DRV.frame(21'h000000, 3'h3, 4, 24, -1);
      pause(20);
      cmp("divide", 3'h5, load_divide_register_o);
      cmp("control", 8'hA5, control_register_o);
      cmp("pulses", 5, pulses);
      cmp("mem kept", 4'h6, memory_index_o);
      cmp("error", 1, program_error_out_b_o);
      $display("end register map test");
      // Abandoned frame, then select pins change
      DRV.frame(21'h1FFFFF, 3'h3, 5, 10, 97);
      DRV.step(1'b1, 1'b0);
      pause(WD / 2);
      cmp("sel early", 2'h0, pixel_select_o);
      pause(WD);
      cmp("sel late", 2'h1, pixel_select_o);
      cmp("pulses", 5, pulses);
      cmp("error", 1, program_error_out_b_o);
      // Second pixel word now active through the gated selects
      DRV.frame({4'h1, 7'h10, 3'h0, 7'h04}, 3'h1, 5, 24, -1);
      pause(20);
      cmp("word b fb", 8'h13, pixel_feedback_count_o);
      cmp("word b ref", 8'h06, pixel_reference_count_o);
      cmp("word b settle", 1, pixel_on_ref_o);
      $display("end watchdog test");
      // Encoding, length, start and stop faults
      for (int k = 0; k < 5; k++) begin
         DRV.frame(21'h0D349B, 3'h1, 5, nb_t[k], bad_t[k]);
         pause(20);
         cmp("error set", 0, program_error_out_b_o);
         cmp("no load", 6, pulses);
         pause(WD + 20);
         cmp("error held", 0, program_error_out_b_o);
      end
      DRV.frame(21'h0D349B, 3'h3, 5, 24, -1);
      pause(20);
      cmp("error clear", 1, program_error_out_b_o);
      cmp("pulses", 7, pulses);
      // Reserved memory band code is flagged
      DRV.frame(21'h00349B, 3'h3, 5, 24, -1);
      pause(20);
      cmp("mem bad", 1, memory_index_bad_o);
      cmp("pulses", 8, pulses);
      $display("end error test");
      conclude();
   end
endmodule // serial_clock_program_loader_bench
